// *** clid_pkg.sv ***
package clid_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int LONG_EXEC_NS = 1_520_000;
    localparam int SHORT_EXEC_NS = 38_000;
    localparam int LONG_EXEC_CYC = (LONG_EXEC_NS + 99) / 100;
    localparam int SHORT_EXEC_CYC = (SHORT_EXEC_NS + 99) / 100;
    localparam int BLINK_MS = 400;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int DISP_RAM_DEPTH = 128;
    localparam int GLYPH_RAM_DEPTH = 64;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] HOME_ADDR = 7'h00;

    // Instruction bit positions.
    localparam int BIT_ADDR_DISP = 7;
    localparam int BIT_ADDR_GLYPH = 6;
    localparam int BIT_FUNC = 5;
    localparam int BIT_SHIFT = 4;
    localparam int BIT_ONOFF = 3;
    localparam int BIT_ENTRY = 2;
    localparam int BIT_HOME = 1;
    localparam int BIT_CLEAR = 0;

    typedef struct packed {
        logic width_8;      // Interface width bit.
        logic two_lines;    // Line count bit.
        logic font_tall;    // Font select.
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic increment;
        logic display_shift_enable;
    } clid_mode_s;

    typedef struct packed {
        logic       busy;
        logic [6:0] address_counter;
        logic [6:0] shift_offset;
        logic       blink_phase;
        logic       glyph_sel;
    } clid_status_s;

endpackage

// *** clid_decoder.sv ***
`timescale 1ns/1ps
// How it works
// - Clear fills display RAM with spaces, counter zero.
// - Clear forces increment direction.
// - Home zeroes counter, undoes shift, keeps RAM.
// - Entry mode sets direction and shift enable.
// - Display RAM writes shift when enabled.
// - On/off holds display, cursor, blink bits.
// - Short font draws cursor on row eight.
// - Blink toggles every 0.4 seconds.
// - Clear/home 1.52ms, others 38us.
// - Status read gives busy and counter.
// - Counter steps after access, shown when idle.
// - Function set holds width, lines, font.
// - Glyph address set selects glyph RAM.
// - Display address set selects display RAM.
// - Data write stores into selected RAM.
// - Data read returns selected RAM byte.
// - Width bit picks 8-bit or nibble transfers.
// - Line bit picks 1/8 or 1/16 duty.
// - Busy device ignores further instructions.
module clid_decoder
    import clid_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic strobe, // One-cycle bus transfer strobe.
    input wire logic register_select, // High selects data, low instruction.
    input wire logic read_not_write, // High for a read.
    input wire logic [7:0] bus_in, // Bus lines from host.
    output logic [7:0] bus_out, // Bus lines to host.
    output logic [7:0] bus_oe, // Per-line output enable.
    output clid_mode_s mode, // Mode settings a cycle late; all zero during reset.
    output clid_status_s status, // Internal state a cycle late; all zero during reset.
    output logic duty_16, // Two-line duty select.
    output logic cursor_row8 // Cursor drawn on eighth row.
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} clid_state_e;

    clid_state_e state_ff, nxt_state;
    clid_mode_s mode_ff, nxt_mode;
    logic [6:0] ac_ff, nxt_ac;
    logic [6:0] shift_ff, nxt_shift;
    logic glyph_ff, nxt_glyph;
    logic [20:0] busy_cnt_ff, nxt_busy_cnt;
    logic [22:0] blink_cnt_ff, nxt_blink_cnt;
    logic blink_ff, nxt_blink;
    logic half_ff, nxt_half;
    logic [3:0] held_ff, nxt_held;
    logic [6:0] pend_ac_ff, nxt_pend_ac;
    logic [7:0] out_ff, nxt_out;
    logic [7:0] oe_ff, nxt_oe;
    logic [6:0] clr_idx_ff, nxt_clr_idx;
    logic [7:0] disp_ram [DISP_RAM_DEPTH];
    logic [7:0] glyph_ram [GLYPH_RAM_DEPTH];

    logic byte_done;
    logic [7:0] byte_val;
    logic wr_disp, wr_glyph;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------

    // Nibble mode pairs two strobes into one byte, high nibble first.
    always_comb
    begin
        nxt_half = half_ff;
        nxt_held = held_ff;
        byte_done = 1'b0;
        byte_val = bus_in;
        if (strobe)
        begin
            if (mode_ff.width_8)
            begin
                byte_done = 1'b1;
            end
            else if (!half_ff)
            begin
                nxt_half = 1'b1;
                nxt_held = bus_in[7:4];
            end
            else
            begin
                nxt_half = 1'b0;
                byte_done = 1'b1;
                byte_val = {held_ff, bus_in[7:4]};
            end
        end
    end

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------

    // Counter steps are parked until the busy time ends, so a poll mid-access shows the old value.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_ac = ac_ff;
        nxt_shift = shift_ff;
        nxt_glyph = glyph_ff;
        nxt_busy_cnt = busy_cnt_ff;
        nxt_pend_ac = pend_ac_ff;
        nxt_clr_idx = clr_idx_ff;
        wr_disp = 1'b0;
        wr_glyph = 1'b0;
        rd_byte = glyph_ff ? glyph_ram[ac_ff[5:0]] : disp_ram[ac_ff];
        case (state_ff)
            ST_IDLE:
            begin
                // Transfers while busy are ignored, except status reads.
                if (byte_done && !(read_not_write && !register_select))
                begin
                    nxt_state = ST_EXEC;
                    nxt_busy_cnt = 21'(SHORT_EXEC_CYC - 1);
                    nxt_pend_ac = ac_ff;
                    if (register_select)
                    begin
                        wr_disp = !read_not_write && !glyph_ff;
                        wr_glyph = !read_not_write && glyph_ff;
                        nxt_pend_ac = mode_ff.increment ? ac_ff + 7'd1 : ac_ff - 7'd1;
                        if (glyph_ff)
                        begin
                            nxt_pend_ac[6] = 1'b0;
                        end
                        if (!read_not_write && !glyph_ff && mode_ff.display_shift_enable)
                        begin
                            nxt_shift = mode_ff.increment ? shift_ff + 7'd1 : shift_ff - 7'd1;
                        end
                    end
                    else if (byte_val[BIT_ADDR_DISP])
                    begin
                        nxt_pend_ac = byte_val[6:0];
                        nxt_glyph = 1'b0;
                    end
                    else if (byte_val[BIT_ADDR_GLYPH])
                    begin
                        nxt_pend_ac = {1'b0, byte_val[5:0]};
                        nxt_glyph = 1'b1;
                    end
                    else if (byte_val[BIT_FUNC])
                    begin
                        nxt_mode.width_8 = byte_val[4];
                        nxt_mode.two_lines = byte_val[3];
                        nxt_mode.font_tall = byte_val[2];
                    end
                    else if (byte_val[BIT_SHIFT])
                    begin
                        if (byte_val[3])
                        begin
                            nxt_shift = byte_val[2] ? shift_ff - 7'd1 : shift_ff + 7'd1;
                        end
                        else
                        begin
                            nxt_pend_ac = byte_val[2] ? ac_ff + 7'd1 : ac_ff - 7'd1;
                        end
                    end
                    else if (byte_val[BIT_ONOFF])
                    begin
                        nxt_mode.display_on = byte_val[2];
                        nxt_mode.cursor_on = byte_val[1];
                        nxt_mode.blink_on = byte_val[0];
                    end
                    else if (byte_val[BIT_ENTRY])
                    begin
                        nxt_mode.increment = byte_val[1];
                        nxt_mode.display_shift_enable = byte_val[0];
                    end
                    else if (byte_val[BIT_HOME])
                    begin
                        nxt_busy_cnt = 21'(LONG_EXEC_CYC - 1);
                        nxt_pend_ac = HOME_ADDR;
                        nxt_shift = 7'd0;
                        nxt_glyph = 1'b0;
                    end
                    else if (byte_val[BIT_CLEAR])
                    begin
                        nxt_state = ST_CLEAR;
                        nxt_busy_cnt = 21'(LONG_EXEC_CYC - 1);
                        nxt_clr_idx = 7'd0;
                        nxt_pend_ac = HOME_ADDR;
                        nxt_shift = 7'd0;
                        nxt_glyph = 1'b0;
                        nxt_mode.increment = 1'b1;
                    end
                end
            end
            ST_EXEC, ST_CLEAR:
            begin
                if (state_ff == ST_CLEAR)
                begin
                    nxt_clr_idx = clr_idx_ff + 7'd1;
                end
                if (busy_cnt_ff == 21'd0)
                begin
                    nxt_state = ST_IDLE;
                    nxt_ac = pend_ac_ff;
                end
                else
                begin
                    nxt_busy_cnt = busy_cnt_ff - 21'd1;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read path and blink
    // ------------------------------------------------------------

    // Read data is re-registered every cycle while read_not_write is high; in nibble mode the low nibble moves up once the first strobe is taken.
    always_comb
    begin
        nxt_out = out_ff;
        nxt_oe = 8'h00;
        nxt_blink_cnt = blink_cnt_ff + 23'd1;
        nxt_blink = blink_ff;
        if (blink_cnt_ff == 23'(BLINK_CYC - 1))
        begin
            nxt_blink_cnt = 23'd0;
            nxt_blink = !blink_ff;
        end
        if (read_not_write)
        begin
            nxt_oe = mode_ff.width_8 ? 8'hFF : 8'hF0;
            if (!register_select)
            begin
                nxt_out = {state_ff != ST_IDLE, ac_ff};
            end
            else
            begin
                nxt_out = rd_byte;
            end
            if (!mode_ff.width_8 && nxt_half)
            begin
                nxt_out = {nxt_out[3:0], 4'h0};
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Clear writes one RAM word per cycle; 128 cycles fit inside the long busy time.
    always_ff @(posedge clk)
    begin
        if (state_ff == ST_CLEAR)
        begin
            disp_ram[clr_idx_ff] <= SPACE_CODE;
        end
        else if (wr_disp)
        begin
            disp_ram[ac_ff] <= byte_val;
        end
        if (wr_glyph)
        begin
            glyph_ram[ac_ff[5:0]] <= byte_val;
        end
    end

    // All control state takes constants at reset.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            mode_ff <= '{width_8: 1'b1, increment: 1'b1, default: 1'b0};
            ac_ff <= HOME_ADDR;
            shift_ff <= 7'd0;
            glyph_ff <= 1'b0;
            busy_cnt_ff <= 21'd0;
            blink_cnt_ff <= 23'd0;
            blink_ff <= 1'b0;
            half_ff <= 1'b0;
            held_ff <= 4'h0;
            pend_ac_ff <= HOME_ADDR;
            out_ff <= 8'h00;
            oe_ff <= 8'h00;
            clr_idx_ff <= 7'd0;
            mode <= '0;
            status <= '0;
            duty_16 <= 1'b0;
            cursor_row8 <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            ac_ff <= nxt_ac;
            shift_ff <= nxt_shift;
            glyph_ff <= nxt_glyph;
            busy_cnt_ff <= nxt_busy_cnt;
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ff <= nxt_blink;
            half_ff <= nxt_half;
            held_ff <= nxt_held;
            pend_ac_ff <= nxt_pend_ac;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            clr_idx_ff <= nxt_clr_idx;
            mode <= mode_ff;
            status <= '{busy: state_ff != ST_IDLE, address_counter: ac_ff, shift_offset: shift_ff,
                        blink_phase: blink_ff && mode_ff.blink_on, glyph_sel: glyph_ff};
            duty_16 <= mode_ff.two_lines;
            cursor_row8 <= mode_ff.cursor_on && !mode_ff.font_tall;
        end
    end

    assign bus_out = out_ff;
    assign bus_oe = oe_ff;

endmodule // clid_decoder

// *** clid_decoder_sva.sv ***
`timescale 1ns/1ps
module clid_decoder_sva
    import clid_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic strobe, // Transfer strobe.
    input wire logic register_select, // Data select.
    input wire logic read_not_write, // Read direction.
    input wire logic [7:0] bus_in, // Host lines.
    input wire logic [7:0] bus_out, // Device lines.
    input wire logic [7:0] bus_oe, // Drive enables.
    input wire clid_mode_s mode, // Mode settings.
    input wire clid_status_s status, // Internal state.
    input wire logic duty_16, // Duty select.
    input wire logic cursor_row8 // Cursor row.
);
    // ------------------------------------------------------------
    // Busy length counter and checks
    // ------------------------------------------------------------
    logic [15:0] busy_len_ff;
    logic [15:0] nxt_busy_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Length of the running busy period, zero from the second idle cycle on.
    always_comb nxt_busy_len = status.busy ? busy_len_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or posedge reset)
        if (reset)
            busy_len_ff <= 16'h0000;
        else
            busy_len_ff <= nxt_busy_len;

    a_exec_time: assert property (
        $fell(status.busy) |-> busy_len_ff inside {[370:390]} || busy_len_ff inside {[15190:15210]})
        else $error("Busy period has the wrong length.");
    a_busy_bounded: assert property (
        status.busy |-> busy_len_ff < 16'd15210) else $error("Busy never ends.");
    a_long_homes: assert property (
        $fell(status.busy) && busy_len_ff > 16'd1000 |-> ##2
        (status.address_counter == 7'h00 && status.shift_offset == 7'h00)) else $error("Counter not homed.");
    a_ac_held_busy: assert property (
        status.busy && busy_len_ff > 16'd2 |-> $stable(status.address_counter)) else $error("Counter moved early.");
    a_mode_frozen: assert property (
        status.busy && busy_len_ff > 16'd10 && busy_len_ff < 16'd360 |=> $stable(mode))
        else $error("Mode changed while busy.");
    a_bus_idle: assert property (
        !read_not_write && !$past(read_not_write) |-> bus_oe == 8'h00) else $error("Bus driven on a write.");
    a_bus_width: assert property (
        read_not_write && $past(read_not_write) && $past(read_not_write, 2)
        |-> bus_oe == (mode.width_8 ? 8'hFF : 8'hF0)) else $error("Wrong drive lanes.");
    a_status_read: assert property (
        read_not_write && $past(read_not_write) && $past(read_not_write, 2) && !register_select
        && !$past(register_select) && mode.width_8 && !status.busy && !$past(status.busy)
        && !$past(status.busy, 2) && status.address_counter == $past(status.address_counter, 2)
        |-> bus_out == {1'b0, status.address_counter}) else $error("Status byte wrong.");
    a_duty_match: assert property (
        mode.two_lines == $past(mode.two_lines) && mode.two_lines == $past(mode.two_lines, 2)
        |-> duty_16 == mode.two_lines) else $error("Duty select wrong.");
    a_cursor_row: assert property (
        mode == $past(mode) && mode == $past(mode, 2)
        |-> cursor_row8 == (mode.cursor_on && !mode.font_tall)) else $error("Cursor row wrong.");
    a_blink_gated: assert property (
        status.blink_phase |-> mode.blink_on) else $error("Blink shown while blink is off.");
    cover property ($fell(status.busy) && busy_len_ff > 16'd1000);
    cover property (bus_oe == 8'hF0);
    cover property (strobe && register_select && !read_not_write);
endmodule // clid_decoder_sva

bind clid_decoder clid_decoder_sva i_clid_decoder_sva (.clk(clk), .reset(reset), .strobe(strobe),
    .register_select(register_select), .read_not_write(read_not_write), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .mode(mode), .status(status), .duty_16(duty_16), .cursor_row8(cursor_row8));

// *** clid_host.sv ***
`timescale 1ns/1ps
module clid_host (
    input wire logic clk, // System clock.
    output logic strobe, // Transfer strobe.
    output logic register_select, // Data select.
    output logic read_not_write, // Read direction.
    output logic [7:0] bus_in, // Lines into the device.
    input wire logic [7:0] bus_out, // Lines from the device.
    input wire logic [7:0] bus_oe // Device drive enables.
);
    // ------------------------------------------------------------
    // Host bus cycles
    // ------------------------------------------------------------
    logic wide = 1'b1;

    // Idle bus at time zero.
    initial
    begin
        strobe = 1'b0;
        register_select = 1'b0;
        read_not_write = 1'b0;
        bus_in = 8'hFF;
    end

    // One strobed transfer; released lines show the inverse so stale data never looks valid.
    task automatic put(input logic rs, input logic rd, input logic [7:0] val);
        @(posedge clk);
        strobe <= 1'b1;
        register_select <= rs;
        read_not_write <= rd;
        bus_in <= val;
        @(posedge clk);
        strobe <= 1'b0;
        bus_in <= ~val;
    endtask

    task automatic send(input logic rs, input logic [7:0] val);
        if (wide)
            put(rs, 1'b0, val);
        else
        begin
            put(rs, 1'b0, {val[7:4], 4'h0});
            put(rs, 1'b0, {val[3:0], 4'h0});
        end
    endtask

    // Poll the busy bit without strobing, so the nibble order is not disturbed.
    task automatic wait_idle();
        int n;
        @(posedge clk);
        register_select <= 1'b0;
        read_not_write <= 1'b1;
        repeat (4) @(posedge clk);
        n = 0;
        while (bus_out[7] !== 1'b0 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
            char_lcd_instruction_decoder_test.timed_out();
        repeat (4) @(posedge clk);
    endtask

    // Present the read early so the high nibble stands on the lines before the first strobe.
    task automatic get(input logic rs, output logic [7:0] val);
        @(posedge clk);
        register_select <= rs;
        read_not_write <= 1'b1;
        repeat (2) @(posedge clk);
        val = bus_out;
        put(rs, 1'b1, 8'h00);
        if (!wide)
        begin
            repeat (2) @(posedge clk);
            val[3:0] = bus_out[7:4];
            put(rs, 1'b1, 8'h00);
        end
    endtask
endmodule // clid_host

// *** char_lcd_instruction_decoder_test.sv ***
`timescale 1ns/1ps
module char_lcd_instruction_decoder_test;
    import clid_pkg::*;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic strobe, register_select, read_not_write, duty_16, cursor_row8;
    logic [7:0] bus_in, bus_out, bus_oe, rd, d;
    logic [6:0] a, sh;
    clid_mode_s mode;
    clid_status_s status;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'hBF6C;

    clid_decoder i_clid_decoder (.clk(clk), .reset(reset), .strobe(strobe), .register_select(register_select),
        .read_not_write(read_not_write), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .mode(mode),
        .status(status), .duty_16(duty_16), .cursor_row8(cursor_row8));
    clid_host i_clid_host (.clk(clk), .strobe(strobe), .register_select(register_select),
        .read_not_write(read_not_write), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));

    // Clock and reset.
    initial
    begin
        fork
            forever #50 clk = ~clk;
            begin
                repeat (12) @(posedge clk);
                reset <= 1'b0;
            end
        join_none
    end

    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Next counter value; the glyph counter wraps at six bits.
    function automatic logic [6:0] step(input logic [6:0] ac, input logic inc, input logic glyph);
        logic [6:0] n;
        n = inc ? ac + 7'h01 : ac - 7'h01;
        return glyph ? {1'b0, n[5:0]} : n;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        end_sim();
    endtask

    task automatic cmd(input logic rs, input logic [7:0] val);
        i_clid_host.send(rs, val);
        i_clid_host.wait_idle();
    endtask

    task automatic read(output logic [7:0] v);
        i_clid_host.get(1'b1, v);
        i_clid_host.wait_idle();
    endtask

    // Main sequence: entry modes on random places, glyph RAM, home, settings, then nibble mode.
    initial
    begin
        // The reset hold stands in for the supply settling time; a full 30 ms wait would exceed the run budget.
        repeat (14) @(posedge clk);
        check({7'h00, mode.width_8}, 8'h01);
        cmd(1'b0, 8'h04);
        cmd(1'b0, 8'h01);
        check({1'b0, status.address_counter}, 8'h00);
        check({7'h00, mode.increment}, 8'h01);
        seed = rnd(seed);
        cmd(1'b0, {1'b1, seed[6:0]});
        read(rd);
        check(rd, SPACE_CODE);
        for (int k = 0; k < 4; k++)
        begin
            seed = rnd(seed);
            a = seed[6:0] % 7'h7E + 7'h01;
            d = seed[15:8];
            cmd(1'b0, {6'h01, k[1:0]});
            cmd(1'b0, {1'b1, a});
            sh = status.shift_offset;
            cmd(1'b1, d);
            check({1'b0, status.address_counter}, {1'b0, step(a, k[1], 1'b0)});
            check({1'b0, status.shift_offset}, {1'b0, sh + (k[0] ? (k[1] ? 7'h01 : 7'h7F) : 7'h00)});
            cmd(1'b0, {1'b1, a});
            sh = status.shift_offset;
            read(rd);
            check(rd, d);
            check({status.glyph_sel, status.address_counter}, {1'b0, step(a, k[1], 1'b0)});
            check({1'b0, status.shift_offset}, {1'b0, sh});
        end
        seed = rnd(seed);
        cmd(1'b0, {2'h1, seed[5:0]});
        check({status.glyph_sel, status.address_counter}, {2'h2, seed[5:0]});
        sh = status.shift_offset;
        cmd(1'b1, seed[15:8]);
        check({1'b0, status.address_counter}, {1'b0, step({1'b0, seed[5:0]}, 1'b1, 1'b1)});
        check({1'b0, status.shift_offset}, {1'b0, sh});
        cmd(1'b0, {2'h1, seed[5:0]});
        read(rd);
        check(rd, seed[15:8]);
        cmd(1'b0, 8'h03);
        check({status.shift_offset, 1'b0}, 8'h00);
        check({1'b0, status.address_counter}, 8'h00);
        cmd(1'b0, {1'b1, a});
        read(rd);
        check(rd, d);
        for (int k = 0; k < 8; k++)
        begin
            cmd(1'b0, {5'h01, k[2:0]});
            check({5'h00, mode.display_on, mode.cursor_on, mode.blink_on}, {5'h00, k[2:0]});
        end
        for (int k = 0; k < 4; k++)
        begin
            cmd(1'b0, {4'h3, k[1:0], 2'h0});
            check({5'h00, mode.two_lines, mode.font_tall, duty_16}, {5'h00, k[1:0], k[1]});
            check({7'h00, cursor_row8}, {7'h00, ~k[0]});
        end
        cmd(1'b0, 8'h20);
        i_clid_host.wide = 1'b0;
        cmd(1'b0, 8'h28);
        cmd(1'b0, 8'h0E);
        i_clid_host.send(1'b0, 8'h01);
        // Let the clear run a while so the stray byte lands mid-busy.
        repeat (50) @(posedge clk);
        i_clid_host.send(1'b0, 8'h0F);
        i_clid_host.wait_idle();
        cmd(1'b0, 8'h06);
        check({mode.width_8, mode.two_lines, mode.display_on, mode.cursor_on, mode.blink_on, mode.increment,
            mode.display_shift_enable, 1'b0}, 8'h74);
        seed = rnd(seed);
        cmd(1'b0, 8'hC5);
        cmd(1'b1, seed[7:0]);
        check({1'b0, status.address_counter}, 8'h46);
        cmd(1'b0, 8'hC5);
        read(rd);
        check(rd, seed[7:0]);
        end_sim();
    end
endmodule // char_lcd_instruction_decoder_test
